// *** src/ufe_defines.svh ***
// Register offsets, field positions and reset values of the front end
`ifndef UFE_DEFINES_SVH
`define UFE_DEFINES_SVH

`define UFE_ADDR_W        8
`define UFE_OFF_RESET     8'h00
`define UFE_OFF_FLAGS     8'h1c
`define UFE_OFF_STICKY    8'h20
`define UFE_OFF_MASKS     8'h24
`define UFE_OFF_SOF       8'h28
`define UFE_OFF_PID       8'h2c
`define UFE_OFF_EP        8'h30
`define UFE_OFF_EPMARK    8'h34
`define UFE_OFF_OTGMASK   8'h38
`define UFE_OFF_PWRSIG    8'h3c
`define UFE_OFF_PHYCTL    8'h40

`define UFE_NFLAGS        7
`define UFE_FLAG_TOKEN    6
`define UFE_FLAG_SE0      5
`define UFE_FLAG_K        4
`define UFE_FLAG_J        3
`define UFE_FLAG_CRC16    2
`define UFE_FLAG_RXACT    1
`define UFE_FLAG_RXERR    0

`define UFE_NPORTS        4
`define UFE_MASK_W        8
`define UFE_SOF_W         11
`define UFE_PID_W         4
`define UFE_EP_W          4
`define UFE_EP_VALID      4
`define UFE_EPMARK_W      16
`define UFE_EP_MARK_BIT   5'h10
`define UFE_PWRSIG_W      9

`define UFE_PHY_PD_DIS    18
`define UFE_PHY_RST_RES   13
`define UFE_PHY_K_RES     12
`define UFE_PHY_DLY_HI    11
`define UFE_PHY_DLY_LO    8
`define UFE_PHY_SUSP      7
`define UFE_PHY_CONF_HI   6
`define UFE_PHY_CONF_LO   4

`define UFE_RESET_VAL     32'h0000_0000
`define UFE_DLY_W         4
`define UFE_CNT_W         16

`endif

// *** src/ufe_pkg.sv ***
// Types shared by the front-end status block
package ufe_pkg;
  typedef logic [31:0] ufe_word_t;
  typedef logic [7:0]  ufe_addr_t;
  typedef logic [1:0]  ufe_ls_t;
  typedef enum logic [1:0] {
    UFE_LS_SE0 = 2'b00,
    UFE_LS_J   = 2'b01,
    UFE_LS_K   = 2'b10,
    UFE_LS_SE1 = 2'b11
  } ufe_ls_e;
endpackage : ufe_pkg

// *** src/ufe_flag_cell.sv ***
// One signal flag with sticky or overwrite behaviour
`timescale 1ns/100ps
module ufe_flag_cell (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic soft_rst,
  input  wire logic sticky,
  input  wire logic sig,
  input  wire logic packet_start,
  input  wire logic clear_w1c,
  output logic      flag
);
  import ufe_pkg::*;
  logic sig_prev;
  logic next_flag;
  logic next_sig_prev;

  always_comb begin
    next_flag     = flag;
    next_sig_prev = sig;
    if (soft_rst) begin
      next_flag     = 1'b0;
      next_sig_prev = 1'b0;
    end else if (sticky) begin
      next_flag = sig | (flag & ~clear_w1c);
    end else if (sig != sig_prev || packet_start) begin
      next_flag = sig;
    end else if (clear_w1c) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag     <= 1'b0;
      sig_prev <= 1'b0;
    end else if (ce) begin
      flag     <= next_flag;
      sig_prev <= next_sig_prev;
    end
  end

  sticky_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && sticky && flag && !clear_w1c && !soft_rst |=> flag)
    else $error("sticky flag lost its value");

  overwrite_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && !sticky && !soft_rst && sig != sig_prev |=> flag == $past(sig))
    else $error("non-sticky flag did not follow its signal");

  packet_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && !sticky && !soft_rst && packet_start && !sig |=> !flag)
    else $error("non-sticky flag not cleared at packet start");
endmodule : ufe_flag_cell

// *** src/ufe_ls_filter.sv ***
// Linestate filter: passes a new state after 2**N stable clocks
`timescale 1ns/100ps
`include "ufe_defines.svh"
module ufe_ls_filter #(
  parameter int CNT_W = `UFE_CNT_W
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  soft_rst,
  input  wire logic [`UFE_DLY_W-1:0] log2_delay,
  input  wire ufe_pkg::ufe_ls_t      ls_raw,
  output ufe_pkg::ufe_ls_t           ls_filt
);
  import ufe_pkg::*;
  ufe_ls_t          cand;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit_m1;
  ufe_ls_t          next_cand;
  ufe_ls_t          next_filt;
  logic [CNT_W-1:0] next_cnt;

  assign limit_m1 = CNT_W'(({{CNT_W{1'b0}}, 1'b1} << log2_delay)
                           - {{CNT_W{1'b0}}, 1'b1});

  always_comb begin
    next_cand = cand;
    next_cnt  = cnt;
    next_filt = ls_filt;
    if (soft_rst) begin
      next_cand = ufe_ls_t'(UFE_LS_SE0);
      next_cnt  = '0;
      next_filt = ufe_ls_t'(UFE_LS_SE0);
    end else if (ls_raw != cand) begin
      next_cand = ls_raw;
      next_cnt  = '0;
    end else if (cnt >= limit_m1) begin
      next_filt = cand;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cand    <= ufe_ls_t'(UFE_LS_SE0);
      cnt     <= '0;
      ls_filt <= ufe_ls_t'(UFE_LS_SE0);
    end else if (ce) begin
      cand    <= next_cand;
      cnt     <= next_cnt;
      ls_filt <= next_filt;
    end
  end

  filter_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && !soft_rst && ls_filt != cand && ls_raw == cand && cnt < limit_m1
    |=> ls_filt == $past(ls_filt))
    else $error("linestate passed before its stable delay");
endmodule : ufe_ls_filter

// *** src/ufe_status_ctrl.sv ***
// Flag, mask, capture and transceiver-control registers of the front end
//
// How it works
// - A stickiness bit per flag makes that flag hold until software writes 1 to it.
// - A flag with stickiness 0 is overwritten by later changes of its signal.
// - Each of four event outputs is high when any flag picked by its 8-bit mask is high.
// - An 11-bit start-of-frame counter, read/write, sits in bits 10:0 and resets to 0.
// - The last received packet identifier is captured into a 4-bit read-only field.
// - The last endpoint is copied read-only with a valid bit in bit 4.
// - A 16-bit mask marks endpoints, which leave on the receive port ORed with 0x10.
// - Control bit 18 turns off the pulldowns on both data ports.
// - An automatic resume by SE0 sets control bit 13 until software writes 0.
// - An automatic resume by K sets control bit 12 until software writes 0.
// - A linestate change passes only after 2**N stable clocks, N in bits 11:8.
// - Control bit 7 hands resume to the suspend controller, else software polls.
// - Control bits 6:4 drive the three transceiver configuration pins.
// - Flags: 6 token, 5 SE0, 4 K, 3 J, 2 CRC16 failure, 1 rx active, 0 rx error.
// - Non-sticky flags reload from their signal when the next packet begins.
`timescale 1ns/100ps
`include "ufe_defines.svh"
module ufe_status_ctrl #(
  parameter int NPORTS = `UFE_NPORTS,
  parameter int CNT_W  = `UFE_CNT_W
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire ufe_pkg::ufe_addr_t      reg_addr,
  input  wire logic                    reg_wr_en,
  input  wire logic                    reg_rd_en,
  input  wire ufe_pkg::ufe_word_t      reg_wdata,
  output ufe_pkg::ufe_word_t           reg_rdata,
  output logic                         reg_rvalid,
  input  wire logic                    token_ok_in,
  input  wire ufe_pkg::ufe_ls_t        linestate_in,
  input  wire logic                    crc16_fail_in,
  input  wire logic                    receive_active_in,
  input  wire logic                    receive_error_in,
  input  wire logic                    packet_start_in,
  input  wire logic                    pid_valid_in,
  input  wire logic [`UFE_PID_W-1:0]   pid_in,
  input  wire logic                    ep_valid_in,
  input  wire logic [`UFE_EP_W-1:0]    ep_in,
  input  wire logic                    sof_valid_in,
  input  wire logic [`UFE_SOF_W-1:0]   sof_frame_in,
  input  wire logic                    resume_se0_in,
  input  wire logic                    resume_k_in,
  output logic                         event_out_a,
  output logic                         event_out_b,
  output logic                         event_out_c,
  output logic                         event_out_d,
  output logic [`UFE_EP_W:0]           rx_endpoint_out,
  output ufe_pkg::ufe_ls_t             linestate_filt,
  output logic                         data_port_low_pd_dis,
  output logic                         data_port_high_pd_dis,
  output logic                         suspend_resume_en,
  output logic [2:0]                   transceiver_config_pins
);
  import ufe_pkg::*;

  logic                       soft_rst;
  logic                       wr_flags;
  logic [`UFE_NFLAGS-1:0]     signal_flags;
  logic [`UFE_NFLAGS-1:0]     flag_sig;
  logic [NPORTS-1:0]          event_out;
  logic [`UFE_NFLAGS-1:0]     flag_stickiness;
  logic [NPORTS*`UFE_MASK_W-1:0] event_port_masks;
  logic [`UFE_SOF_W-1:0]      frame_start_count;
  logic [`UFE_PID_W-1:0]      last_packet_ident;
  logic [`UFE_EP_W:0]         last_endpoint;
  logic [`UFE_EPMARK_W-1:0]   endpoint_marking;
  ufe_word_t                  otg_flag_mask;
  logic [`UFE_PWRSIG_W-1:0]   power_signalling;
  ufe_word_t                  transceiver_control;
  ufe_word_t                  rd_mux;

  logic [`UFE_NFLAGS-1:0]     next_stickiness;
  logic [NPORTS*`UFE_MASK_W-1:0] next_masks;
  logic [`UFE_SOF_W-1:0]      next_sof;
  logic [`UFE_PID_W-1:0]      next_pid;
  logic [`UFE_EP_W:0]         next_ep;
  logic [`UFE_EP_W:0]         next_rx_ep;
  logic [`UFE_EPMARK_W-1:0]   next_epmark;
  ufe_word_t                  next_otg;
  logic [`UFE_PWRSIG_W-1:0]   next_pwrsig;
  ufe_word_t                  next_phy;
  ufe_word_t                  next_rdata;
  logic                       next_rvalid;

  // Front-end reset: any write to the reset word
  assign soft_rst = reg_wr_en && reg_addr == `UFE_OFF_RESET;
  assign wr_flags = reg_wr_en && reg_addr == `UFE_OFF_FLAGS;

  // Monitored signals behind each flag
  always_comb begin
    flag_sig = '0;
    flag_sig[`UFE_FLAG_TOKEN] = token_ok_in;
    flag_sig[`UFE_FLAG_SE0]   = linestate_filt == ufe_ls_t'(UFE_LS_SE0);
    flag_sig[`UFE_FLAG_K]     = linestate_filt == ufe_ls_t'(UFE_LS_K);
    flag_sig[`UFE_FLAG_J]     = linestate_filt == ufe_ls_t'(UFE_LS_J);
    flag_sig[`UFE_FLAG_CRC16] = crc16_fail_in;
    flag_sig[`UFE_FLAG_RXACT] = receive_active_in;
    flag_sig[`UFE_FLAG_RXERR] = receive_error_in;
  end

  for (genvar f = 0; f < `UFE_NFLAGS; f++) begin : g_flag
    ufe_flag_cell u_cell (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .ce           (ce),
      .soft_rst     (soft_rst),
      .sticky       (flag_stickiness[f]),
      .sig          (flag_sig[f]),
      .packet_start (packet_start_in),
      .clear_w1c    (wr_flags && reg_wdata[f]),
      .flag         (signal_flags[f])
    );
  end

  // Event outputs straight from flags and masks
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    assign event_out[p] = |(event_port_masks[p*`UFE_MASK_W +: `UFE_NFLAGS]
                            & signal_flags);
  end
  assign event_out_a = event_out[0];
  assign event_out_b = event_out[1];
  assign event_out_c = event_out[2];
  assign event_out_d = event_out[3];

  ufe_ls_filter #(
    .CNT_W (CNT_W)
  ) u_filter (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .soft_rst   (soft_rst),
    .log2_delay (transceiver_control[`UFE_PHY_DLY_HI:`UFE_PHY_DLY_LO]),
    .ls_raw     (linestate_in),
    .ls_filt    (linestate_filt)
  );

  // Transceiver-side controls
  assign data_port_low_pd_dis    = transceiver_control[`UFE_PHY_PD_DIS];
  assign data_port_high_pd_dis   = transceiver_control[`UFE_PHY_PD_DIS];
  assign suspend_resume_en       = transceiver_control[`UFE_PHY_SUSP];
  assign transceiver_config_pins =
    transceiver_control[`UFE_PHY_CONF_HI:`UFE_PHY_CONF_LO];

  // Register writes and hardware captures
  always_comb begin
    next_stickiness = flag_stickiness;
    next_masks      = event_port_masks;
    next_sof        = frame_start_count;
    next_pid        = last_packet_ident;
    next_ep         = last_endpoint;
    next_rx_ep      = rx_endpoint_out;
    next_epmark     = endpoint_marking;
    next_otg        = otg_flag_mask;
    next_pwrsig     = power_signalling;
    next_phy        = transceiver_control;
    if (reg_wr_en) begin
      unique case (reg_addr)
        `UFE_OFF_STICKY:  next_stickiness = reg_wdata[`UFE_NFLAGS-1:0];
        `UFE_OFF_MASKS:   next_masks = reg_wdata;
        `UFE_OFF_SOF:     next_sof = reg_wdata[`UFE_SOF_W-1:0];
        `UFE_OFF_EPMARK:  next_epmark = reg_wdata[`UFE_EPMARK_W-1:0];
        `UFE_OFF_OTGMASK: next_otg = reg_wdata;
        `UFE_OFF_PWRSIG:  next_pwrsig = reg_wdata[`UFE_PWRSIG_W-1:0];
        `UFE_OFF_PHYCTL: begin
          next_phy = `UFE_RESET_VAL;
          next_phy[`UFE_PHY_PD_DIS]  = reg_wdata[`UFE_PHY_PD_DIS];
          next_phy[`UFE_PHY_RST_RES] = reg_wdata[`UFE_PHY_RST_RES];
          next_phy[`UFE_PHY_K_RES]   = reg_wdata[`UFE_PHY_K_RES];
          next_phy[`UFE_PHY_DLY_HI:`UFE_PHY_DLY_LO] =
            reg_wdata[`UFE_PHY_DLY_HI:`UFE_PHY_DLY_LO];
          next_phy[`UFE_PHY_SUSP:`UFE_PHY_CONF_LO] =
            reg_wdata[`UFE_PHY_SUSP:`UFE_PHY_CONF_LO];
        end
        default: ;
      endcase
    end
    // Hardware events win over a register write in the same cycle; a front-end reset wins over both
    if (sof_valid_in) begin
      next_sof = sof_frame_in;
    end
    if (pid_valid_in) begin
      next_pid = pid_in;
    end
    if (ep_valid_in) begin
      next_ep = {1'b1, ep_in};
      next_rx_ep = {1'b0, ep_in}
                   | (endpoint_marking[ep_in] ? `UFE_EP_MARK_BIT : 5'h00);
    end
    if (resume_se0_in) begin
      next_phy[`UFE_PHY_RST_RES] = 1'b1;
    end
    if (resume_k_in) begin
      next_phy[`UFE_PHY_K_RES] = 1'b1;
    end
    if (soft_rst) begin
      next_stickiness = '0;
      next_masks      = '0;
      next_sof        = '0;
      next_pid        = '0;
      next_ep         = '0;
      next_rx_ep      = '0;
      next_epmark     = '0;
      next_otg        = `UFE_RESET_VAL;
      next_pwrsig     = '0;
      next_phy        = `UFE_RESET_VAL;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_stickiness     <= '0;
      event_port_masks    <= '0;
      frame_start_count   <= '0;
      last_packet_ident   <= '0;
      last_endpoint       <= '0;
      rx_endpoint_out     <= '0;
      endpoint_marking    <= '0;
      otg_flag_mask       <= `UFE_RESET_VAL;
      power_signalling    <= '0;
      transceiver_control <= `UFE_RESET_VAL;
    end else if (ce) begin
      flag_stickiness     <= next_stickiness;
      event_port_masks    <= next_masks;
      frame_start_count   <= next_sof;
      last_packet_ident   <= next_pid;
      last_endpoint       <= next_ep;
      rx_endpoint_out     <= next_rx_ep;
      endpoint_marking    <= next_epmark;
      otg_flag_mask       <= next_otg;
      power_signalling    <= next_pwrsig;
      transceiver_control <= next_phy;
    end
  end

  // Read path, one cycle after the read strobe
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      `UFE_OFF_FLAGS:   rd_mux[`UFE_NFLAGS-1:0] = signal_flags;
      `UFE_OFF_STICKY:  rd_mux[`UFE_NFLAGS-1:0] = flag_stickiness;
      `UFE_OFF_MASKS:   rd_mux = event_port_masks;
      `UFE_OFF_SOF:     rd_mux[`UFE_SOF_W-1:0] = frame_start_count;
      `UFE_OFF_PID:     rd_mux[`UFE_PID_W-1:0] = last_packet_ident;
      `UFE_OFF_EP:      rd_mux[`UFE_EP_W:0] = last_endpoint;
      `UFE_OFF_EPMARK:  rd_mux[`UFE_EPMARK_W-1:0] = endpoint_marking;
      `UFE_OFF_OTGMASK: rd_mux = otg_flag_mask;
      `UFE_OFF_PWRSIG:  rd_mux[`UFE_PWRSIG_W-1:0] = power_signalling;
      `UFE_OFF_PHYCTL:  rd_mux = transceiver_control;
      default:          rd_mux = '0;
    endcase
    next_rdata  = reg_rd_en ? rd_mux : reg_rdata;
    next_rvalid = reg_rd_en;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  event_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    event_out_b == |(event_port_masks[`UFE_MASK_W +: `UFE_NFLAGS]
                     & signal_flags))
    else $error("event output b does not match its mask");

  sof_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && sof_valid_in && !soft_rst |=> frame_start_count == $past(sof_frame_in))
    else $error("frame counter did not load");

  pid_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && pid_valid_in && !soft_rst |=> last_packet_ident == $past(pid_in))
    else $error("packet identifier not captured");

  ep_valid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && ep_valid_in && !soft_rst
    |=> last_endpoint == {1'b1, $past(ep_in)})
    else $error("endpoint copy or valid bit wrong");

  ep_mark_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && ep_valid_in && !soft_rst
    |=> rx_endpoint_out[`UFE_EP_W] == $past(endpoint_marking[ep_in]))
    else $error("endpoint marking wrong on receive port");

  se0_resume_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && resume_se0_in && !soft_rst
    |=> transceiver_control[`UFE_PHY_RST_RES])
    else $error("reset-resume cause bit not set");

  se0_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && transceiver_control[`UFE_PHY_RST_RES] && !soft_rst
    && !(reg_wr_en && reg_addr == `UFE_OFF_PHYCTL)
    |=> transceiver_control[`UFE_PHY_RST_RES])
    else $error("reset-resume cause bit lost");

  k_resume_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && resume_k_in && !soft_rst |=> transceiver_control[`UFE_PHY_K_RES])
    else $error("K-resume cause bit not set");

  conf_pins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_wr_en && reg_addr == `UFE_OFF_PHYCTL
    |=> transceiver_config_pins
        == $past(reg_wdata[`UFE_PHY_CONF_HI:`UFE_PHY_CONF_LO]))
    else $error("configuration pins do not follow control bits");

  pulldown_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    data_port_low_pd_dis == transceiver_control[`UFE_PHY_PD_DIS]
    && data_port_high_pd_dis == data_port_low_pd_dis)
    else $error("pulldown disables disagree");

  soft_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && soft_rst |=> transceiver_control == `UFE_RESET_VAL
                       && event_port_masks == '0 && signal_flags == '0)
    else $error("front-end reset left state behind");
endmodule : ufe_status_ctrl

// *** bench/ufe_phy_model.sv ***
// Transceiver and packet-decoder side driving the front end
`timescale 1ns/100ps
module ufe_phy_model (
  input  wire logic          ref_clk,
  output logic               token_ok_in,
  output ufe_pkg::ufe_ls_t   linestate_in,
  output logic               crc16_fail_in,
  output logic               receive_active_in,
  output logic               receive_error_in,
  output logic               packet_start_in,
  output logic               pid_valid_in,
  output logic [3:0]         pid_in,
  output logic               ep_valid_in,
  output logic [3:0]         ep_in,
  output logic               sof_valid_in,
  output logic [10:0]        sof_frame_in,
  output logic               resume_se0_in,
  output logic               resume_k_in
);
  import ufe_pkg::*;
  logic [7:0] strobe;
  // Strobe bits: 0 token, 1 CRC16, 2 packet start, 3 pid, 4 endpoint, 5 frame, 6 SE0 resume, 7 K resume
  assign {resume_k_in, resume_se0_in, sof_valid_in, ep_valid_in} = strobe[7:4];
  assign {pid_valid_in, packet_start_in, crc16_fail_in} = strobe[3:1];
  assign token_ok_in = strobe[0];
  initial begin
    strobe = 8'h00;
    linestate_in = UFE_LS_J;
    receive_active_in = 1'b0;
    receive_error_in = 1'b0;
    pid_in = 4'h0;
    ep_in = 4'h0;
    sof_frame_in = 11'h000;
  end
  task automatic pulse(input int idx);
    @(posedge ref_clk);
    strobe[idx] <= 1'b1;
    @(posedge ref_clk);
    strobe[idx] <= 1'b0;
  endtask : pulse
  // Fields change to their inverse once the strobe is gone
  task automatic capture(input logic [3:0] p, input logic [3:0] e,
                         input logic [10:0] s);
    @(posedge ref_clk);
    pid_in <= p;
    ep_in <= e;
    sof_frame_in <= s;
    strobe[5:3] <= 3'h7;
    @(posedge ref_clk);
    strobe[5:3] <= 3'h0;
    pid_in <= ~p;
    ep_in <= ~e;
    sof_frame_in <= ~s;
  endtask : capture
  task automatic level(input logic act, input logic err);
    @(posedge ref_clk);
    receive_active_in <= act;
    receive_error_in <= err;
  endtask : level
  task automatic line(input ufe_ls_t ls);
    @(posedge ref_clk);
    linestate_in <= ls;
  endtask : line
endmodule : ufe_phy_model

// *** bench/ufe_status_ctrl_test.sv ***
// Self-checking bench for the front-end status block
`timescale 1ns/100ps
`include "ufe_defines.svh"
module ufe_status_ctrl_test;
  import ufe_pkg::*;
  logic ref_clk, rst_n, reg_wr_en, reg_rd_en, reg_rvalid;
  ufe_addr_t reg_addr;
  ufe_word_t reg_wdata, reg_rdata;
  logic tok, crc, ract, rerr, pst, pidv, epv, sofv, rse0, rk;
  logic [3:0] pid, ep, ev;
  logic [10:0] sof;
  logic [4:0] rx_ep;
  logic [5:0] pins;
  logic ce, ev_a, ev_b, ev_c, ev_d, pd_lo, pd_hi, susp;
  logic [2:0] conf;
  assign ev = {ev_d, ev_c, ev_b, ev_a};
  assign pins = {pd_lo, pd_hi, susp, conf};
  ufe_ls_t ls, filt;
  int num_errors = 0;
  int checked = 0;
  ufe_addr_t offs [5] = '{8'h20, 8'h28, 8'h34, 8'h38, 8'h3c};
  ufe_word_t lim [5] = '{32'h7f, 32'h7ff, 32'hffff, 32'hffffffff, 32'h1ff};
  ufe_status_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .token_ok_in(tok), .linestate_in(ls), .crc16_fail_in(crc),
    .receive_active_in(ract), .receive_error_in(rerr),
    .packet_start_in(pst), .pid_valid_in(pidv), .pid_in(pid),
    .ep_valid_in(epv), .ep_in(ep), .sof_valid_in(sofv),
    .sof_frame_in(sof), .resume_se0_in(rse0), .resume_k_in(rk),
    .event_out_a(ev_a), .event_out_b(ev_b), .event_out_c(ev_c),
    .event_out_d(ev_d), .rx_endpoint_out(rx_ep), .linestate_filt(filt),
    .data_port_low_pd_dis(pd_lo), .data_port_high_pd_dis(pd_hi),
    .suspend_resume_en(susp), .transceiver_config_pins(conf));
  ufe_phy_model u_phy (.ref_clk(ref_clk), .token_ok_in(tok),
    .linestate_in(ls), .crc16_fail_in(crc), .receive_active_in(ract),
    .receive_error_in(rerr), .packet_start_in(pst), .pid_valid_in(pidv),
    .pid_in(pid), .ep_valid_in(epv), .ep_in(ep), .sof_valid_in(sofv),
    .sof_frame_in(sof), .resume_se0_in(rse0), .resume_k_in(rk));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input ufe_word_t exp,
                     input ufe_word_t got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input ufe_addr_t a, input ufe_word_t d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(input ufe_addr_t a, input ufe_word_t m,
                     input ufe_word_t exp, input string what);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (reg_rvalid !== 1'b1) begin
      num_errors++;
      close_out();
    end
    chk(what, exp, reg_rdata & m);
  endtask : rdc
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 32'h0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdc(8'h20 + 8'(4 * i), '1, 32'h0, "reset value");
    end
    for (int i = 0; i < 5; i++) begin
      wr(offs[i], '1);
      rdc(offs[i], '1, lim[i], "field width");
    end
    wr(`UFE_OFF_PID, '1);
    wr(`UFE_OFF_EP, '1);
    rdc(`UFE_OFF_PID, '1, 32'h0, "pid read only");
    rdc(`UFE_OFF_EP, '1, 32'h0, "ep read only");
    rdc(8'h44, '1, 32'h0, "unmapped");
    wr(`UFE_OFF_RESET, 32'h0);
    rdc(`UFE_OFF_STICKY, '1, 32'h0, "soft reset");
    rdc(`UFE_OFF_SOF, '1, 32'h0, "soft reset sof");
    u_phy.level(1'b0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      wr(`UFE_OFF_MASKS, 32'h1 << (8 * k));
      chk("event ports", 32'(4'h1 << k), 32'(ev));
    end
    u_phy.level(1'b1, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("event ports low", 32'h0, 32'(ev));
    rdc(`UFE_OFF_FLAGS, 32'h3, 32'h2, "rx flags");
    wr(`UFE_OFF_STICKY, 32'h44);
    wr(`UFE_OFF_MASKS, 32'h40);
    u_phy.pulse(0);
    u_phy.pulse(1);
    u_phy.pulse(2);
    rdc(`UFE_OFF_FLAGS, 32'h44, 32'h44, "sticky flags");
    chk("token event", 32'h1, 32'(ev));
    wr(`UFE_OFF_FLAGS, 32'h4);
    rdc(`UFE_OFF_FLAGS, 32'h44, 32'h40, "flag clear");
    u_phy.pulse(1);
    wr(`UFE_OFF_STICKY, 32'h0);
    u_phy.pulse(2);
    rdc(`UFE_OFF_FLAGS, 32'h4, 32'h0, "packet clear");
    wr(`UFE_OFF_EPMARK, 32'h20);
    u_phy.capture(4'ha, 4'h5, 11'h5a3);
    #1;
    chk("rx endpoint", 32'h15, 32'(rx_ep));
    rdc(`UFE_OFF_PID, '1, 32'ha, "pid");
    rdc(`UFE_OFF_EP, '1, 32'h15, "endpoint");
    rdc(`UFE_OFF_SOF, '1, 32'h5a3, "frame");
    u_phy.capture(4'h3, 4'h3, 11'h000);
    #1;
    chk("rx endpoint plain", 32'h3, 32'(rx_ep));
    u_phy.pulse(6);
    rdc(`UFE_OFF_PHYCTL, 32'h3000, 32'h2000, "se0 resume");
    wr(`UFE_OFF_PHYCTL, 32'h0);
    rdc(`UFE_OFF_PHYCTL, 32'h3000, 32'h0, "resume clear");
    u_phy.pulse(7);
    rdc(`UFE_OFF_PHYCTL, 32'h3000, 32'h1000, "k resume");
    wr(`UFE_OFF_PHYCTL, 32'h200);
    u_phy.line(UFE_LS_K);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("filter early", 32'(UFE_LS_J), 32'(filt));
    @(posedge ref_clk);
    #1;
    chk("filter on time", 32'(UFE_LS_K), 32'(filt));
    rdc(`UFE_OFF_FLAGS, 32'h38, 32'h10, "k flag");
    wr(`UFE_OFF_PHYCTL, 32'h400f0);
    chk("phy pins", 32'h3f, 32'(pins));
    rdc(`UFE_OFF_PHYCTL, '1, 32'h400f0, "phy control");
    wr(`UFE_OFF_PHYCTL, 32'h20);
    chk("phy pins low", 32'h2, 32'(pins));
    @(posedge ref_clk);
    ce <= 1'b0;
    u_phy.pulse(6);
    wr(`UFE_OFF_PHYCTL, 32'h0);
    chk("frozen pins", 32'h2, 32'(pins));
    @(posedge ref_clk);
    ce <= 1'b1;
    rdc(`UFE_OFF_PHYCTL, '1, 32'h20, "frozen control");
    close_out();
  end
endmodule : ufe_status_ctrl_test
